// File: core/egd_consts.vh
// constants for the two-wire eeprom target with write guard
`ifndef EGD_CONSTS_VH
`define EGD_CONSTS_VH

// device type codes in the device select byte
`define EGD_TYPE_MEM      4'b1010
`define EGD_TYPE_CFG      4'b1011

// config space select, top three address bits with the config type
`define EGD_SEL_SWP       3'b100
`define EGD_SEL_LOCK      3'b101
`define EGD_SEL_CDA       3'b110
`define EGD_SEL_DTI       3'b111

// register values
`define EGD_DTI_VALUE     8'hb1
`define EGD_CDA_RESET     8'h00
`define EGD_SWP_RESET     8'h00
`define EGD_CDA_MASK      8'h0f
`define EGD_SWP_MASK      8'h03
`define EGD_LOCK_BIT      1

// array geometry
`define EGD_ADDR_W        16
`define EGD_PAGE_W        7
`define EGD_FIFO_W        25

// protection field encodings
`define EGD_SWP_NONE      2'b00
`define EGD_SWP_QUARTER   2'b01
`define EGD_SWP_HALF      2'b10
`define EGD_SWP_ALL       2'b11

// timing
`define EGD_CLK_PERIOD_NS 8
`define EGD_WRITE_TIME_NS 4000000
`define EGD_WRITE_CYC     (`EGD_WRITE_TIME_NS / `EGD_CLK_PERIOD_NS)
`define EGD_BUSY_W        20

// bus engine states
`define EGD_ST_IDLE       3'd0
`define EGD_ST_RX         3'd1
`define EGD_ST_ACKW       3'd2
`define EGD_ST_RACK       3'd3
`define EGD_ST_TX         3'd4
`define EGD_ST_TACK       3'd5
`define EGD_ST_TACKD      3'd6
`define EGD_ST_IGN        3'd7

`endif

// File: core/egd_sync.v
// three-stage synchroniser with agreement filter for pin inputs
`default_nettype none

module egd_sync #(
  parameter RESET_VAL = 1'b1
) (
  input  wire clk_sys,
  input  wire resetn,
  input  wire pin_in,
  output reg  level_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // only the second stage reads the first
  always @(posedge clk_sys) begin
    if (!resetn) begin
      s1_q    <= RESET_VAL;
      s2_q    <= RESET_VAL;
      s3_q    <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule // egd_sync

`default_nettype wire

// File: core/egd_fifo2.v
// small valid/ready buffer, two entries by default
`default_nettype none

module egd_fifo2 #(
  parameter W     = 25,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rp_q];

  always @(posedge clk_sys) begin
    if (!resetn) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // egd_fifo2

`default_nettype wire

// File: core/egd_eeprom.v
// two-wire eeprom target: bus engine, write guard, array and config space
`default_nettype none
`include "egd_consts.vh"

module egd_eeprom #(
  parameter WRITE_CYC = `EGD_WRITE_CYC
) (
  input  wire clk_sys,
  input  wire resetn,
  input  wire scl_in,
  input  wire sda_in,
  output reg  sda_out_q,
  output reg  sda_oe_q,
  input  wire write_protect_input,
  input  wire array_hold,
  output reg  standby_q,
  output reg  write_busy_q
);

  // synchronised pins
  wire scl_s;
  wire sda_s;
  wire wp_s;

  egd_sync #(.RESET_VAL(1'b1)) u_sync_scl (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pin_in  (scl_in),
    .level_q (scl_s)
  );

  egd_sync #(.RESET_VAL(1'b1)) u_sync_sda (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pin_in  (sda_in),
    .level_q (sda_s)
  );

  // reset value high keeps writes refused until the pin is seen
  egd_sync #(.RESET_VAL(1'b1)) u_sync_wp (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pin_in  (write_protect_input),
    .level_q (wp_s)
  );

  // storage
  reg [7:0] mem_q  [0:(1<<`EGD_ADDR_W)-1];
  reg [7:0] idpg_q [0:(1<<`EGD_PAGE_W)-1];

  // engine state
  reg [2:0]  st_q;
  reg [3:0]  cnt_q;
  reg [7:0]  sh_q;
  reg [7:0]  tx_q;
  reg [1:0]  idx_q;
  reg        rw_q;
  reg        cfg_q;
  reg        ack_q;
  reg        scl_prev_q;
  reg        sda_prev_q;
  reg [15:0] addr_q;
  reg [7:0]  cda_q;
  reg [7:0]  swp_q;
  reg        idlock_q;
  reg [7:0]  stg_q;
  reg [2:0]  stg_sel_q;
  reg [1:0]  stg_n_q;
  reg        wr_any_q;
  reg [`EGD_BUSY_W-1:0] bcnt_q;

  wire scl_rise = scl_s && !scl_prev_q;
  wire scl_fall = !scl_s && scl_prev_q;
  wire start_ev = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  wire stop_ev  = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  wire [7:0] byte_nx = {sh_q[6:0], sda_s};
  wire       byte_done = scl_rise && (st_q == `EGD_ST_RX) &&
                         (cnt_q == 4'd7);
  wire [2:0] sel = addr_q[15:13];

  function prot_hit;
    input [15:0] a;
    input [1:0]  mode;
    begin
      case (mode)
        `EGD_SWP_NONE:    prot_hit = 1'b0;
        `EGD_SWP_QUARTER: prot_hit = (a[15:14] == 2'b11);
        `EGD_SWP_HALF:    prot_hit = a[15];
        default:          prot_hit = 1'b1;
      endcase
    end
  endfunction

  // buffer toward the array write port
  wire                  f_in_ready;
  wire                  f_out_valid;
  wire [`EGD_FIFO_W-1:0] f_out_data;
  wire                  to_buf = !cfg_q || !addr_q[15];
  reg                   wr_ok_d;
  reg [7:0]             rd_d;

  always @* begin
    if (!cfg_q) begin
      wr_ok_d = !prot_hit(addr_q, swp_q[1:0]);
    end else if (!addr_q[15]) begin
      wr_ok_d = !idlock_q;
    end else begin
      case (sel)
        `EGD_SEL_CDA:  wr_ok_d = !cda_q[0];
        `EGD_SEL_SWP:  wr_ok_d = 1'b1;
        `EGD_SEL_LOCK: wr_ok_d = 1'b1;
        default:       wr_ok_d = 1'b0;
      endcase
    end
    if (wp_s) begin
      wr_ok_d = 1'b0;
    end
    if (to_buf && !f_in_ready) begin
      wr_ok_d = 1'b0;
    end
  end

  always @* begin
    if (!cfg_q) begin
      rd_d = mem_q[addr_q];
    end else if (!addr_q[15]) begin
      rd_d = idpg_q[addr_q[6:0]];
    end else begin
      case (sel)
        `EGD_SEL_CDA: rd_d = cda_q;
        `EGD_SEL_DTI: rd_d = `EGD_DTI_VALUE;
        `EGD_SEL_SWP: rd_d = swp_q;
        default:      rd_d = {7'h00, idlock_q};
      endcase
    end
  end

  wire data_phase = (idx_q == 2'd3) && !rw_q;
  wire push = byte_done && data_phase && wr_ok_d && to_buf;

  egd_fifo2 #(.W(`EGD_FIFO_W), .DEPTH(2), .AW(1)) u_buf (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   ({~cfg_q, addr_q, byte_nx}),
    .out_valid (f_out_valid),
    .out_ready (!array_hold),
    .out_data  (f_out_data)
  );

  // drain: high bit picks array or identification page
  always @(posedge clk_sys) begin
    if (f_out_valid && !array_hold) begin
      if (f_out_data[24]) begin
        mem_q[f_out_data[23:8]] <= f_out_data[7:0];
      end else begin
        idpg_q[f_out_data[14:8]] <= f_out_data[7:0];
      end
    end
  end

  // resetn stands for the power-on-reset: while low nothing answers
  always @(posedge clk_sys) begin
    if (!resetn) begin
      st_q         <= `EGD_ST_IDLE;
      cnt_q        <= 4'd0;
      sh_q         <= 8'h00;
      tx_q         <= 8'h00;
      idx_q        <= 2'd0;
      rw_q         <= 1'b0;
      cfg_q        <= 1'b0;
      ack_q        <= 1'b0;
      scl_prev_q   <= 1'b1;
      sda_prev_q   <= 1'b1;
      addr_q       <= 16'h0000;
      cda_q        <= `EGD_CDA_RESET;
      swp_q        <= `EGD_SWP_RESET;
      idlock_q     <= 1'b0;
      stg_q        <= 8'h00;
      stg_sel_q    <= 3'd0;
      stg_n_q      <= 2'd0;
      wr_any_q     <= 1'b0;
      bcnt_q       <= {`EGD_BUSY_W{1'b0}};
      sda_out_q    <= 1'b0;
      sda_oe_q     <= 1'b0;
      standby_q    <= 1'b0;
      write_busy_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      sda_out_q  <= 1'b0;
      write_busy_q <= (bcnt_q != {`EGD_BUSY_W{1'b0}});
      standby_q  <= (st_q == `EGD_ST_IDLE) && (bcnt_q == {`EGD_BUSY_W{1'b0}})
                    && !f_out_valid;
      if (bcnt_q != {`EGD_BUSY_W{1'b0}}) begin
        bcnt_q <= bcnt_q - 1'b1;
      end
      if (stop_ev) begin
        st_q     <= `EGD_ST_IDLE;
        sda_oe_q <= 1'b0;
        wr_any_q <= 1'b0;
        stg_n_q  <= 2'd0;
        if (stg_n_q == 2'd1) begin
          case (stg_sel_q)
            `EGD_SEL_CDA:  cda_q <= stg_q & `EGD_CDA_MASK;
            `EGD_SEL_SWP:  swp_q <= stg_q & `EGD_SWP_MASK;
            default:       idlock_q <= idlock_q | stg_q[`EGD_LOCK_BIT];
          endcase
        end
        // more than one config byte: nothing stored, no cycle
        if (wr_any_q && stg_n_q < 2'd2) begin
          bcnt_q <= WRITE_CYC[`EGD_BUSY_W-1:0];
        end
      end else if (start_ev) begin
        st_q     <= `EGD_ST_RX;
        cnt_q    <= 4'd0;
        idx_q    <= 2'd0;
        sda_oe_q <= 1'b0;
      end else begin
        case (st_q)
          `EGD_ST_RX: begin
            if (scl_rise) begin
              sh_q  <= byte_nx;
              cnt_q <= cnt_q + 4'd1;
            end
            if (byte_done) begin
              st_q  <= `EGD_ST_ACKW;
              ack_q <= 1'b1;
              if (idx_q == 2'd0) begin
                rw_q  <= byte_nx[0];
                cfg_q <= (byte_nx[7:4] == `EGD_TYPE_CFG);
                ack_q <= (byte_nx[7:4] == `EGD_TYPE_MEM ||
                          byte_nx[7:4] == `EGD_TYPE_CFG) &&
                         (byte_nx[3:1] == cda_q[3:1]) &&
                         (bcnt_q == {`EGD_BUSY_W{1'b0}});
              end else if (idx_q == 2'd1) begin
                addr_q[15:8] <= byte_nx;
              end else if (idx_q == 2'd2) begin
                addr_q[7:0] <= byte_nx;
              end else begin
                ack_q <= wr_ok_d;
                if (wr_ok_d) begin
                  wr_any_q <= 1'b1;
                  addr_q[6:0] <= addr_q[6:0] + 7'd1;
                  if (!to_buf) begin
                    stg_q     <= byte_nx;
                    stg_sel_q <= sel;
                    stg_n_q   <= (stg_n_q == 2'd3) ? 2'd3 : stg_n_q + 2'd1;
                  end
                end else if (!to_buf && stg_n_q != 2'd0) begin
                  stg_n_q <= 2'd2;
                end
              end
              if (idx_q != 2'd3) begin
                idx_q <= idx_q + 2'd1;
              end
            end
          end
          `EGD_ST_ACKW: begin
            if (scl_fall) begin
              if (ack_q) begin
                sda_oe_q <= 1'b1;
                st_q     <= `EGD_ST_RACK;
              end else begin
                st_q <= `EGD_ST_IGN;
              end
            end
          end
          `EGD_ST_RACK: begin
            if (scl_fall) begin
              cnt_q <= 4'd0;
              if (rw_q) begin
                // first read bit goes out on the same falling edge
                tx_q     <= rd_d;
                sda_oe_q <= !rd_d[7];
                cnt_q    <= 4'd1;
                st_q     <= `EGD_ST_TX;
              end else begin
                sda_oe_q <= 1'b0;
                st_q     <= `EGD_ST_RX;
              end
            end
          end
          `EGD_ST_TX: begin
            if (scl_fall) begin
              if (cnt_q == 4'd8) begin
                sda_oe_q <= 1'b0;
                st_q     <= `EGD_ST_TACK;
              end else begin
                sda_oe_q <= !tx_q[3'd7 - cnt_q[2:0]];
                cnt_q    <= cnt_q + 4'd1;
              end
            end
          end
          `EGD_ST_TACK: begin
            if (scl_rise) begin
              ack_q  <= !sda_s;
              addr_q <= addr_q + 16'h0001;
              st_q   <= `EGD_ST_TACKD;
            end
          end
          `EGD_ST_TACKD: begin
            if (scl_fall) begin
              if (ack_q) begin
                tx_q     <= rd_d;
                sda_oe_q <= !rd_d[7];
                cnt_q    <= 4'd1;
                st_q     <= `EGD_ST_TX;
              end else begin
                st_q <= `EGD_ST_IGN;
              end
            end
          end
          `EGD_ST_IGN: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            st_q <= `EGD_ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // egd_eeprom

`default_nettype wire

// File: testbench/egd_eeprom_assertions.sv
// assertion checker bound to the two-wire eeprom target
`default_nettype none
module egd_eeprom_assertions #(
  parameter int WRITE_CYC = 400
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out_q,
  input wire logic sda_oe_q,
  input wire logic write_protect_input,
  input wire logic array_hold,
  input wire logic standby_q,
  input wire logic write_busy_q
);
  int busy_len_q;

  // counts the cycles of the current internal write
  always @(posedge clk_sys) begin
    if (!resetn || !write_busy_q)
      busy_len_q <= 0;
    else
      busy_len_q <= busy_len_q + 1;
  end

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  AST_OPEN_DRAIN: assert property (!sda_out_q)
    else $error("data value not low");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    !resetn |=> !sda_oe_q) else $error("line pulled in reset");
  AST_RST_IDLE: assert property (disable iff (1'b0)
    !resetn |=> !write_busy_q && !standby_q) else $error("reset state wrong");
  AST_STBY_UP: assert property ($rose(resetn) |-> ##[1:3] standby_q)
    else $error("no standby after reset");
  AST_BUSY_STBY: assert property (write_busy_q |-> !standby_q)
    else $error("standby during write");
  AST_BUSY_SILENT: assert property (write_busy_q |-> !sda_oe_q)
    else $error("line pulled during write");
  // the pin itself must be low when the line driver moves
  AST_OE_SCL_LOW: assert property ($changed(sda_oe_q) |->
    !scl_in && !$past(scl_in))
    else $error("data changed with clock high");
  AST_WRITE_LEN: assert property ($fell(write_busy_q) |->
    busy_len_q >= WRITE_CYC - 1 && busy_len_q <= WRITE_CYC + 1)
    else $error("write cycle length wrong");
endmodule // egd_eeprom_assertions

bind egd_eeprom egd_eeprom_assertions #(.WRITE_CYC(WRITE_CYC)) u_egd_chk (
  .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .array_hold(array_hold),
  .write_protect_input(write_protect_input), .standby_q(standby_q),
  .write_busy_q(write_busy_q));
`default_nettype wire

// File: testbench/egd_ctl.sv
// two-wire bus controller model that drives the eeprom's bus pins
`default_nettype none
module egd_ctl (
  input  wire logic clk_sys,
  input  wire logic sda_w,
  output var  logic scl,
  output var  logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus: clock stands high, data released to the pull-up
  initial scl = 1'b1;
  initial sda_pull = 1'b0;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // long low phase: the target answers about five clocks after our fall,
  // so the low phase must outlast that or it moves data with clock high
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_pull <= !b;
    tick(4);
    scl <= 1'b1;
    tick(1);
    @(negedge clk_sys);
    r = sda_w;
    tick(1);
    scl <= 1'b0;
  endtask

  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] r, output logic nack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(last, nack);
  endtask

  task automatic start();
    tick(2);
    sda_pull <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(4);
  endtask
endmodule // egd_ctl
`default_nettype wire

// File: testbench/egd_eeprom_tb_top.sv
// self-checking bench for the two-wire eeprom target
`default_nettype none
`include "egd_consts.vh"
`define CHK(nm, e, a) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    n_errors++; \
    $display("MISMATCH %s exp %h seen %h", nm, e, a); \
  end \
end
module egd_eeprom_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       write_protect_input = 1'b0;
  logic       array_hold = 1'b0;
  wire logic  scl_in;
  wire logic  sda_pull;
  wire logic  sda_oe_q;
  wire logic  standby_q;
  wire logic  write_busy_q;
  wire logic  sda_w;
  int         n_errors = 0;
  int         cmp_count = 0;
  logic [7:0] rv;
  logic       nk;

  always #4 clk_sys = ~clk_sys;
  // pull-up: the line is low only while a party pulls it
  assign sda_w = !(sda_pull || sda_oe_q);

  egd_eeprom #(.WRITE_CYC(400)) u_egd_eeprom (
    .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_w),
    .sda_out_q(), .sda_oe_q(sda_oe_q), .array_hold(array_hold),
    .write_protect_input(write_protect_input), .standby_q(standby_q),
    .write_busy_q(write_busy_q));
  egd_ctl u_egd_ctl (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl_in),
    .sda_pull(sda_pull));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic sb(input logic [7:0] d, input logic ack);
    u_egd_ctl.xfer(d, 1'b1, rv, nk);
    `CHK("ack", ack, !nk)
  endtask

  task automatic head(input logic [7:0] ds, input logic [15:0] a);
    u_egd_ctl.start();
    sb(ds, 1'b1);
    sb(a[15:8], 1'b1);
    sb(a[7:0], 1'b1);
  endtask

  task automatic rd(input logic [7:0] ds, input logic [15:0] a,
                    input logic [15:0] e, input int n);
    head(ds, a);
    u_egd_ctl.start();
    sb(ds | 8'h01, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_egd_ctl.xfer(8'hff, i == n - 1, rv, nk);
      `CHK("read", e[15 - 8 * i -: 8], rv)
    end
    u_egd_ctl.stop();
  endtask

  task automatic commit(input logic busy, input logic poll);
    u_egd_ctl.stop();
    tick(6);
    `CHK("busy", busy, write_busy_q)
    if (poll) begin
      u_egd_ctl.start();
      sb(8'ha0, 1'b0);
      u_egd_ctl.stop();
    end
    for (int k = 0; k < 1000 && write_busy_q !== 1'b0; k++)
      tick(1);
    tick(3);
    `CHK("standby", 1'b1, standby_q)
  endtask

  initial begin
    tick(10);
    resetn <= 1'b1;
    tick(12); // wake-up delay before the first command
    `CHK("standby", 1'b1, standby_q)
    head(8'ha0, 16'h1234);
    sb(8'h5a, 1'b1);
    sb(8'hc3, 1'b1);
    commit(1'b1, 1'b1);
    rd(8'ha0, 16'h1234, 16'h5ac3, 2);
    head(8'ha0, 16'h127f);
    sb(8'h11, 1'b1);
    sb(8'h22, 1'b1);
    commit(1'b1, 1'b0);
    rd(8'ha0, 16'h1200, 16'h2200, 1);
    write_protect_input <= 1'b1;
    head(8'ha0, 16'h1234);
    sb(8'h00, 1'b0);
    commit(1'b0, 1'b0);
    head(8'hb0, 16'hc000);
    sb(8'h02, 1'b0);
    commit(1'b0, 1'b0);
    write_protect_input <= 1'b0;
    rd(8'ha0, 16'h1234, 16'h5ac3, 2);
    // a held array port must stall, not drop, the buffered bytes
    array_hold <= 1'b1;
    head(8'ha0, 16'h2000);
    sb(8'h01, 1'b1);
    sb(8'h02, 1'b1);
    sb(8'h03, 1'b0);
    array_hold <= 1'b0;
    commit(1'b1, 1'b0);
    rd(8'ha0, 16'h2000, 16'h0102, 2);
    rd(8'hb0, 16'he000, {`EGD_DTI_VALUE, 8'h00}, 1);
    head(8'hb0, 16'he000);
    sb(8'h00, 1'b0);
    commit(1'b0, 1'b0);
    head(8'hb0, 16'hc000);
    sb(8'h02, 1'b1);
    u_egd_ctl.xfer(8'h04, 1'b1, rv, nk);
    commit(1'b0, 1'b0);
    head(8'hb0, 16'hc000);
    sb(8'h02, 1'b1);
    commit(1'b1, 1'b0);
    u_egd_ctl.start();
    sb(8'ha0, 1'b0);
    u_egd_ctl.stop();
    rd(8'ha2, 16'h1234, 16'h5ac3, 2);
    head(8'hb2, 16'h0010);
    sb(8'h5e, 1'b1);
    commit(1'b1, 1'b0);
    rd(8'hb2, 16'h0010, 16'h5e00, 1);
    head(8'hb2, 16'ha000);
    sb(8'h02, 1'b1);
    commit(1'b1, 1'b0);
    head(8'hb2, 16'h0010);
    sb(8'h00, 1'b0);
    commit(1'b0, 1'b0);
    head(8'hb2, 16'h8000);
    sb(8'h03, 1'b1);
    commit(1'b1, 1'b0);
    head(8'ha2, 16'h0040);
    sb(8'h00, 1'b0);
    head(8'ha2, 16'h1234);
    resetn <= 1'b0;
    u_egd_ctl.start();
    sb(8'ha2, 1'b0);
    resetn <= 1'b1;
    u_egd_ctl.stop();
    tick(12);
    rd(8'ha0, 16'h1234, 16'h5ac3, 2);
    close_out();
  end

  initial begin
    tick(60000);
    n_errors++;
    close_out();
  end
endmodule // egd_eeprom_tb_top
`default_nettype wire
